// [core/gate_driver_defs.vh]
// Purpose: Shared constants for the gate driver protection control.
// Assumes: 20 MHz mclk (50 ns period).
// Notes:   Times are kept in their own unit; the deglitch cycle count derives from them.
`ifndef GATE_DRIVER_DEFS_VH
`define GATE_DRIVER_DEFS_VH

`define CLK_PERIOD_NS        50
`define DEGLITCH_TIME_NS     40
// Least time, rounded up, never below one cycle
`define DEGLITCH_CYCLES      ((`DEGLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_FREQ_HZ          20000000
`define MON_PWM_FREQ_HZ      400000
`define MON_PERIOD_CYCLES    (`CLK_FREQ_HZ / `MON_PWM_FREQ_HZ)
`define MON_DUTY_MAX_PCT     95
`define MON_DUTY_MIN_PCT     5
`define SHORT_LEVEL_W        8
`define FAULT_MUTE_CYCLES    64
`define RESET_FILTER_CYCLES  32
// Lockout flags start asserted so the gate stays off until supplies are seen
`define FLAG_SYNC_RESET      5'h18
`define PCT_FULL_SCALE       100

`endif

// [core/input_deglitch.v]
// Purpose: Two-flop synchroniser followed by a pulse-rejection filter.
// Assumes: Input is asynchronous to mclk.
// Notes:   Output changes only after the new level has held FILTER_CYCLES+1 samples.
`timescale 1ns/1ps
`default_nettype none
module input_deglitch #(
    parameter integer FILTER_CYCLES = 1,
    parameter         RESET_VALUE   = 1'b0
) (
    input  wire       mclk,
    input  wire       srst,
    input  wire       pin_in,
    output reg        level_out
);
    reg       meta_reg;
    reg       sync_reg;
    reg [7:0] hold_reg;

    always @(posedge mclk)
    begin
        if (srst)
        begin
            meta_reg  <= RESET_VALUE;
            sync_reg  <= RESET_VALUE;
            hold_reg  <= 8'h00;
            level_out <= RESET_VALUE;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            if (sync_reg == level_out)
                hold_reg <= 8'h00;
            else if (hold_reg >= FILTER_CYCLES[7:0])
            begin
                level_out <= sync_reg;
                hold_reg  <= 8'h00;
            end
            else
                hold_reg <= hold_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [core/gate_driver_protection_control.v]
// Purpose: Protection and control logic of an isolated single-channel gate driver.
// Assumes: Comparator and lockout flags arrive as asynchronous logic levels.
// Notes:   Open-drain pins appear as output enables; high means pulling low.
// How it works
// - Overcurrent is only looked at while the gate output is high.
// - An armed overcurrent starts a soft turn-off and raises a fault.
// - After a fault the gate stays low, unless a short request forces it high, until cleared by the reset input.
// - A fault pulls the open-drain alarm low until a valid reset.
// - Reset requests are ignored during the mute interval after a fault.
// - Reset held low past the filter time clears the fault on its rising edge.
// - Reset/enable low disables the driver through the normal turn-off.
// - A short request with output supplies up forces gate high and clamp low.
// - The monitor pin carries 400kHz PWM, 95% duty at 0V down to 5% at 5V; the code gives 47 of 50 cycles (94%) down to 2 (4%).
// - The clamp enable rises when the gate is off and below the clamp threshold.
// - Gate follows PWM only with both supply sides out of lockout; a short request needs only the output side up.
// - Any lockout pulls the open-drain ready output low.
// - Gate is low when both PWM inputs are high, high only for pos high, neg low.
// - Pulses under 40ns on the PWM and reset inputs are rejected.
`timescale 1ns/1ps
`default_nettype none
`include "gate_driver_defs.vh"
module gate_driver_protection_control #(
    parameter integer FAULT_MUTE_CYCLES   = `FAULT_MUTE_CYCLES,
    parameter integer RESET_FILTER_CYCLES = `RESET_FILTER_CYCLES,
    parameter integer LEVEL_W             = `SHORT_LEVEL_W
) (
    input  wire               mclk,
    input  wire               srst,
    input  wire               pwm_pos_in,
    input  wire               pwm_neg_in,
    input  wire               reset_enable_n,
    input  wire               active_short_request,
    input  wire               overcurrent_sense,
    input  wire               clamp_threshold_below,
    input  wire               input_supply_lockout,
    input  wire               output_supply_lockout,
    input  wire [LEVEL_W-1:0] short_request_level,
    output reg                gate_drive_out,
    output reg                soft_turnoff,
    output reg                sense_pulldown,
    output reg                clamp_fet_enable,
    output reg                fault_alarm_n_oe,
    output reg                ready_oe,
    output reg                short_level_pwm_out
);
    localparam integer MON_PERIOD = `MON_PERIOD_CYCLES;
    localparam integer LEVEL_MAX  = (1 << LEVEL_W) - 1;
    localparam integer SPAN       = `MON_DUTY_MAX_PCT - `MON_DUTY_MIN_PCT;

    wire pos_f;
    wire neg_f;
    wire rst_en_f;

    input_deglitch #(.FILTER_CYCLES(`DEGLITCH_CYCLES), .RESET_VALUE(1'b0)) u_pos (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (pwm_pos_in),
        .level_out (pos_f)
    );
    input_deglitch #(.FILTER_CYCLES(`DEGLITCH_CYCLES), .RESET_VALUE(1'b0)) u_neg (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (pwm_neg_in),
        .level_out (neg_f)
    );
    // Starts low so an undriven enable keeps the part off
    input_deglitch #(.FILTER_CYCLES(`DEGLITCH_CYCLES), .RESET_VALUE(1'b0)) u_rst (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (reset_enable_n),
        .level_out (rst_en_f)
    );

    // Two-flop synchronisers for the analog-side flags
    reg [4:0]         flag_meta_reg;
    reg [4:0]         flag_sync_reg;
    reg [LEVEL_W-1:0] level_meta_reg;
    reg [LEVEL_W-1:0] level_sync_reg;
    always @(posedge mclk)
    begin
        if (srst)
        begin
            flag_meta_reg  <= `FLAG_SYNC_RESET;
            flag_sync_reg  <= `FLAG_SYNC_RESET;
            level_meta_reg <= {LEVEL_W{1'b0}};
            level_sync_reg <= {LEVEL_W{1'b0}};
        end
        else
        begin
            flag_meta_reg  <= {input_supply_lockout, output_supply_lockout,
                               clamp_threshold_below, overcurrent_sense,
                               active_short_request};
            flag_sync_reg  <= flag_meta_reg;
            level_meta_reg <= short_request_level;
            level_sync_reg <= level_meta_reg;
        end
    end
    wire short_s  = flag_sync_reg[0];
    wire oc_s     = flag_sync_reg[1];
    wire clamp_s  = flag_sync_reg[2];
    wire out_supply_lockout = flag_sync_reg[3];
    wire in_supply_lockout  = flag_sync_reg[4];

    // Fault latch with mute window and reset filter
    reg        fault_reg;
    reg [15:0] mute_cnt_reg;
    reg [15:0] low_cnt_reg;
    reg        reset_armed_reg;
    reg        rst_en_d_reg;
    wire       rst_rise   = rst_en_f & ~rst_en_d_reg;
    wire       muted      = mute_cnt_reg != 16'h0000;
    // Detection only while the gate is high
    wire       oc_trip    = oc_s & gate_drive_out & ~fault_reg;

    always @(posedge mclk)
    begin
        if (srst)
        begin
            fault_reg       <= 1'b0;
            mute_cnt_reg    <= 16'h0000;
            low_cnt_reg     <= 16'h0000;
            reset_armed_reg <= 1'b0;
            rst_en_d_reg    <= 1'b0;
        end
        else
        begin
            rst_en_d_reg <= rst_en_f;
            if (oc_trip)
            begin
                fault_reg       <= 1'b1;
                mute_cnt_reg    <= FAULT_MUTE_CYCLES[15:0];
                reset_armed_reg <= 1'b0;
                low_cnt_reg     <= 16'h0000;
            end
            else
            begin
                if (muted)
                    mute_cnt_reg <= mute_cnt_reg - 16'h0001;
                // Low time counted only after the mute ends
                if (rst_en_f || muted)
                    low_cnt_reg <= 16'h0000;
                else if (low_cnt_reg < 16'hFFFF)
                    low_cnt_reg <= low_cnt_reg + 16'h0001;
                if (!rst_en_f && !muted && low_cnt_reg >= RESET_FILTER_CYCLES[15:0])
                    reset_armed_reg <= 1'b1;
                // Clear lands on the rising edge
                if (rst_rise && reset_armed_reg)
                begin
                    fault_reg       <= 1'b0;
                    reset_armed_reg <= 1'b0;
                end
            end
        end
    end

    // Gate decision
    reg gate_next;
    reg soft_next;
    always @*
    begin
        gate_next = 1'b0;
        soft_next = 1'b0;
        if (short_s && !out_supply_lockout)
            gate_next = 1'b1;
        else if (in_supply_lockout || out_supply_lockout)
            gate_next = 1'b0;
        else if (fault_reg || oc_trip)
        begin
            gate_next = 1'b0;
            soft_next = 1'b1;
        end
        else if (!rst_en_f)
            gate_next = 1'b0; // Normal path, no soft stage
        else
            gate_next = pos_f & ~neg_f;
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            gate_drive_out   <= 1'b0;
            soft_turnoff     <= 1'b0;
            sense_pulldown   <= 1'b1;
            clamp_fet_enable <= 1'b0;
            fault_alarm_n_oe <= 1'b0;
            ready_oe         <= 1'b1;
        end
        else
        begin
            gate_drive_out   <= gate_next;
            soft_turnoff     <= soft_next & ~gate_next;
            sense_pulldown   <= ~gate_next;
            // Forced low under a short request with the output supply up
            clamp_fet_enable <= ~gate_next & clamp_s & ~(short_s & ~out_supply_lockout);
            fault_alarm_n_oe <= fault_reg | oc_trip;
            ready_oe         <= in_supply_lockout | out_supply_lockout;
        end
    end

    // Monitor PWM: duty = 95% - 90% * level / full scale
    reg  [7:0]  mon_cnt_reg;
    reg  [7:0]  mon_high_reg;
    wire [31:0] duty_prod  = SPAN * MON_PERIOD * level_sync_reg;
    wire [31:0] high_calc  = (`MON_DUTY_MAX_PCT * MON_PERIOD) / `PCT_FULL_SCALE
                             - duty_prod / (`PCT_FULL_SCALE * LEVEL_MAX);
    always @(posedge mclk)
    begin
        if (srst)
        begin
            mon_cnt_reg         <= 8'h00;
            mon_high_reg        <= 8'h00;
            short_level_pwm_out <= 1'b0;
        end
        else
        begin
            if (mon_cnt_reg == MON_PERIOD[7:0] - 8'h01)
            begin
                mon_cnt_reg  <= 8'h00;
                // Duty is sampled once per period so no runt pulses appear
                mon_high_reg <= high_calc[7:0];
            end
            else
                mon_cnt_reg <= mon_cnt_reg + 8'h01;
            short_level_pwm_out <= mon_cnt_reg < mon_high_reg;
        end
    end
endmodule
`default_nettype wire

// [verification/gate_driver_monitor.sv]
// Purpose: Port assertions for the gate driver protection control.
// Assumes: Inputs held steady long enough to pass the synchronisers.
// Notes:   Held-input windows absorb the sync and filter delay.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_monitor #(
    parameter integer FAULT_MUTE_CYCLES   = 64,
    parameter integer RESET_FILTER_CYCLES = 32,
    parameter integer LEVEL_W             = 8
) (
    input wire logic               mclk,
    input wire logic               srst,
    input wire logic               pwm_pos_in,
    input wire logic               pwm_neg_in,
    input wire logic               reset_enable_n,
    input wire logic               active_short_request,
    input wire logic               overcurrent_sense,
    input wire logic               clamp_threshold_below,
    input wire logic               input_supply_lockout,
    input wire logic               output_supply_lockout,
    input wire logic [LEVEL_W-1:0] short_request_level,
    input wire logic               gate_drive_out,
    input wire logic               soft_turnoff,
    input wire logic               sense_pulldown,
    input wire logic               clamp_fet_enable,
    input wire logic               fault_alarm_n_oe,
    input wire logic               ready_oe,
    input wire logic               short_level_pwm_out
);
    logic [15:0] alarm_cnt_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Counts how long the alarm has been pulling low
    always_ff @(posedge mclk)
        alarm_cnt_reg <= (srst || !fault_alarm_n_oe) ? 16'h0000 : alarm_cnt_reg + 16'h0001;
    a_lockout_gate: assert property ((output_supply_lockout || input_supply_lockout &&
        !active_short_request)[*5] |-> !gate_drive_out) else $error("gate high in lockout");
    a_lockout_ready: assert property ((input_supply_lockout || output_supply_lockout)[*4]
        |-> ready_oe) else $error("ready not pulled in lockout");
    a_sense_held: assert property (!gate_drive_out |-> sense_pulldown)
        else $error("sense not pulled down while gate off");
    // A gate that is off must never let a new fault latch on the next edge
    a_idle_no_trip: assert property (!gate_drive_out && !fault_alarm_n_oe |=>
        !fault_alarm_n_oe) else $error("fault raised while gate off");
    a_trip_alarm: assert property ((gate_drive_out && overcurrent_sense &&
        !active_short_request)[*3] |-> ##[0:2] fault_alarm_n_oe) else $error("trip not seen");
    a_fault_holds: assert property ((fault_alarm_n_oe && !active_short_request)[*4]
        |-> !gate_drive_out && soft_turnoff) else $error("gate not held off on fault");
    a_mute_time: assert property ($fell(fault_alarm_n_oe) |->
        alarm_cnt_reg > FAULT_MUTE_CYCLES + RESET_FILTER_CYCLES) else $error("fault cleared early");
    a_alarm_latch: assert property ((fault_alarm_n_oe && reset_enable_n)[*8]
        |=> fault_alarm_n_oe) else $error("alarm released without reset");
    a_short_force: assert property ((active_short_request && !output_supply_lockout)[*4]
        |-> gate_drive_out && !clamp_fet_enable) else $error("short request not forcing gate");
    a_interlock_low: assert property ((pwm_pos_in && pwm_neg_in &&
        !active_short_request)[*6] |-> !gate_drive_out) else $error("interlock gate high");
endmodule
bind gate_driver_protection_control gate_driver_monitor #(
    .FAULT_MUTE_CYCLES(FAULT_MUTE_CYCLES),
    .RESET_FILTER_CYCLES(RESET_FILTER_CYCLES),
    .LEVEL_W(LEVEL_W)
) mon (.*);
`default_nettype wire

// [verification/host_model.sv]
// Purpose: Host controller driving PWM and reset/enable.
// Assumes: Commands change only at the falling clock edge.
// Notes:   Enable is always driven, never left floating.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic pos_cmd,
    input  wire logic neg_cmd,
    input  wire logic en_cmd,
    output wire logic pwm_pos_in,
    output wire logic pwm_neg_in,
    output wire logic reset_enable_n
);
    assign pwm_pos_in     = pos_cmd;
    assign pwm_neg_in     = neg_cmd;
    assign reset_enable_n = en_cmd;
endmodule
`default_nettype wire

// [verification/gate_driver_protection_control_tb.sv]
// Purpose: Self-checking bench for the gate driver protection control.
// Assumes: Default mute 64 and filter 32 cycles.
// Notes:   Outputs are judged at falling edges, where they are settled.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_protection_control_tb;
    logic mclk = 1'b0, srst = 1'b1, pos_cmd = 1'b0, neg_cmd = 1'b0, en_cmd = 1'b0;
    logic active_short_request = 1'b0, overcurrent_sense = 1'b0, clamp_threshold_below = 1'b0;
    logic input_supply_lockout = 1'b0, output_supply_lockout = 1'b0;
    logic [7:0] short_request_level = 8'h00;
    wire pwm_pos_in, pwm_neg_in, reset_enable_n, gate_drive_out, soft_turnoff, sense_pulldown;
    wire clamp_fet_enable, fault_alarm_n_oe, ready_oe, short_level_pwm_out;
    integer err_count = 0, total_checks = 0;
    always #25 mclk = ~mclk;
    host_model host (.*);
    gate_driver_protection_control dut (.*);
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task t_pwm;
        en_cmd = 1'b1;
        wt(8);
        // Enable settles first, so only the filter can keep a one-cycle pulse off the gate
        pos_cmd = 1'b1;
        wt(1);
        pos_cmd = 1'b0;
        repeat (8)
        begin
            wt(1);
            chk("glitch gate", 8'h00, gate_drive_out);
        end
        pos_cmd = 1'b1;
        wt(8);
        chk("gate on", 8'h01, gate_drive_out); chk("sense", 8'h00, sense_pulldown);
        neg_cmd = 1'b1; clamp_threshold_below = 1'b1; wt(8);
        chk("interlock", 8'h00, gate_drive_out); chk("clamp", 8'h01, clamp_fet_enable);
        neg_cmd = 1'b0; en_cmd = 1'b0; wt(8);
        chk("disable", 8'h00, gate_drive_out); chk("normal off", 8'h00, soft_turnoff);
        // Overcurrent while the gate is off must not latch a fault
        overcurrent_sense = 1'b1;
        wt(8);
        chk("idle trip", 8'h00, fault_alarm_n_oe);
        overcurrent_sense = 1'b0;
    endtask
    task t_lockout;
        en_cmd = 1'b1; input_supply_lockout = 1'b1; wt(8);
        chk("in lock gate", 8'h00, gate_drive_out); chk("ready", 8'h01, ready_oe);
        input_supply_lockout = 1'b0; output_supply_lockout = 1'b1; wt(8);
        chk("out lock gate", 8'h00, gate_drive_out); chk("ready", 8'h01, ready_oe);
        output_supply_lockout = 1'b0; wt(8);
        chk("ready free", 8'h00, ready_oe); chk("gate back", 8'h01, gate_drive_out);
        chk("clamp gate on", 8'h00, clamp_fet_enable);
    endtask
    task t_short;
        pos_cmd = 1'b0; en_cmd = 1'b0; input_supply_lockout = 1'b1; active_short_request = 1'b1;
        wt(8);
        chk("short gate", 8'h01, gate_drive_out); chk("short clamp", 8'h00, clamp_fet_enable);
        active_short_request = 1'b0; input_supply_lockout = 1'b0; wt(8);
    endtask
    task t_monitor(input logic [7:0] lvl, input integer exp);
        integer hi;
        hi = 0;
        short_request_level = lvl; wt(120);
        repeat (50)
        begin
            wt(1);
            hi += short_level_pwm_out;
        end
        chk("monitor duty", exp[7:0], hi[7:0]);
    endtask
    task t_fault;
        pos_cmd = 1'b1; en_cmd = 1'b1; clamp_threshold_below = 1'b0; wt(8);
        overcurrent_sense = 1'b1; wt(5);
        chk("alarm", 8'h01, fault_alarm_n_oe); chk("gate off", 8'h00, gate_drive_out);
        chk("soft", 8'h01, soft_turnoff);
        overcurrent_sense = 1'b0; en_cmd = 1'b0; wt(10); en_cmd = 1'b1; wt(70);
        chk("muted reset", 8'h01, fault_alarm_n_oe); chk("latched", 8'h00, gate_drive_out);
        en_cmd = 1'b0; wt(20); en_cmd = 1'b1; wt(10);
        chk("short reset", 8'h01, fault_alarm_n_oe);
        en_cmd = 1'b0; wt(40); en_cmd = 1'b1; wt(10);
        chk("cleared", 8'h00, fault_alarm_n_oe); chk("resumed", 8'h01, gate_drive_out);
    endtask
    initial
    begin
        wt(20);
        srst = 1'b0;
        wt(8);
        t_pwm;
        t_lockout;
        t_short;
        t_monitor(8'h00, 47);
        t_monitor(8'hFF, 2);
        t_fault;
        test_done;
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        test_done;
    end
endmodule
`default_nettype wire
